/* File: hw/jcmr_pkg.sv */
// Constants and types for the test-port configuration readback block.
// Assumes a 10-bit instruction register and 32-bit configuration words.
package jcmr_pkg;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
    TAP_PA_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR,
    TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
  } jcmr_tap_t;

  // Packet header layout
  typedef struct packed {
    logic [2:0]  kind;
    logic [1:0]  op;
    logic [8:0]  rsv_hi;
    logic [4:0]  addr;
    logic [1:0]  rsv_lo;
    logic [10:0] count;
  } jcmr_hdr_t;

  localparam int unsigned WORD_W       = 32;
  localparam int unsigned IR_W         = 10;
  localparam int unsigned CNT_W        = 27;
  localparam logic [9:0]  IR_CFG_IN    = 10'h3C5;
  localparam logic [9:0]  IR_CFG_OUT   = 10'h3C4;
  localparam logic [9:0]  IR_SHUTDOWN  = 10'h3CD;
  localparam logic [9:0]  IR_BYPASS    = 10'h3FF;
  localparam logic [9:0]  IR_CAPTURE   = 10'h001;
  localparam logic [31:0] SYNC_WORD    = 32'hAA995566;
  localparam logic [2:0]  HDR_TYPE1    = 3'h1;
  localparam logic [2:0]  HDR_TYPE2    = 3'h2;
  localparam logic [1:0]  OP_READ      = 2'h1;
  localparam logic [1:0]  OP_WRITE     = 2'h2;
  localparam logic [4:0]  REG_FAR      = 5'h01;
  localparam logic [4:0]  REG_FRAME_RD = 5'h03;
  localparam logic [4:0]  REG_CMD      = 5'h04;
  localparam logic [4:0]  RESET_CRC_COMMAND          = 5'h07;
  localparam logic [4:0]  READ_CONFIGURATION_COMMAND = 5'h04;
  // Idle cycles in the shutdown state, counted on the link clock
  localparam logic [3:0]  SHUTDOWN_TCK = 4'hC;
  // Words in one frame; plain default
  localparam logic [7:0]  FRAME_WORDS  = 8'h51;
  localparam logic [4:0]  LAST_BIT     = 5'h1F;

endpackage

/* File: hw/jcmr_readback.sv */
// Test access port with configuration input, output and shutdown paths.
// Frame memory sits on clk_i and answers in the cycle of rd_req_o.
`timescale 1ns/1ps

// Summary of operation
// - First frame shifted out is zero dummy data; host discards it.
// - Twelve idle TCK cycles after shutdown instruction complete shutdown.
// - Configuration-done output is low while shutdown is in progress.
// - Output instruction streams frame data out through Shift-DR.
module jcmr_readback (
  // System clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // Test port, own clock
  input  wire logic        tck_i,
  input  wire logic        tms_i,
  input  wire logic        tdi_i,
  output logic             tdo_o,
  output logic             tdo_en_o,
  // Frame memory read port
  output logic             rd_req_o,
  output logic [31:0]      rd_addr_o,
  input  wire logic [31:0] rd_data_i,
  // Status
  output logic             done_o
);

  // Reset carried into the link domain
  logic rst_meta_n;
  logic rst_sync_n;
  always_ff @(posedge tck_i) begin
    rst_meta_n <= reset_n_i;
    rst_sync_n <= rst_meta_n;
  end
  wire tck_rst = !rst_sync_n;

  jcmr_pkg::jcmr_tap_t tap;
  jcmr_pkg::jcmr_tap_t next_tap;
  always_comb begin
    case (tap)
      jcmr_pkg::TAP_RESET:  next_tap = tms_i ? jcmr_pkg::TAP_RESET  : jcmr_pkg::TAP_IDLE;
      jcmr_pkg::TAP_IDLE:   next_tap = tms_i ? jcmr_pkg::TAP_SEL_DR : jcmr_pkg::TAP_IDLE;
      jcmr_pkg::TAP_SEL_DR: next_tap = tms_i ? jcmr_pkg::TAP_SEL_IR : jcmr_pkg::TAP_CAP_DR;
      jcmr_pkg::TAP_CAP_DR: next_tap = tms_i ? jcmr_pkg::TAP_EX1_DR : jcmr_pkg::TAP_SH_DR;
      jcmr_pkg::TAP_SH_DR:  next_tap = tms_i ? jcmr_pkg::TAP_EX1_DR : jcmr_pkg::TAP_SH_DR;
      jcmr_pkg::TAP_EX1_DR: next_tap = tms_i ? jcmr_pkg::TAP_UPD_DR : jcmr_pkg::TAP_PA_DR;
      jcmr_pkg::TAP_PA_DR:  next_tap = tms_i ? jcmr_pkg::TAP_EX2_DR : jcmr_pkg::TAP_PA_DR;
      jcmr_pkg::TAP_EX2_DR: next_tap = tms_i ? jcmr_pkg::TAP_UPD_DR : jcmr_pkg::TAP_SH_DR;
      jcmr_pkg::TAP_UPD_DR: next_tap = tms_i ? jcmr_pkg::TAP_SEL_DR : jcmr_pkg::TAP_IDLE;
      jcmr_pkg::TAP_SEL_IR: next_tap = tms_i ? jcmr_pkg::TAP_RESET  : jcmr_pkg::TAP_CAP_IR;
      jcmr_pkg::TAP_CAP_IR: next_tap = tms_i ? jcmr_pkg::TAP_EX1_IR : jcmr_pkg::TAP_SH_IR;
      jcmr_pkg::TAP_SH_IR:  next_tap = tms_i ? jcmr_pkg::TAP_EX1_IR : jcmr_pkg::TAP_SH_IR;
      jcmr_pkg::TAP_EX1_IR: next_tap = tms_i ? jcmr_pkg::TAP_UPD_IR : jcmr_pkg::TAP_PA_IR;
      jcmr_pkg::TAP_PA_IR:  next_tap = tms_i ? jcmr_pkg::TAP_EX2_IR : jcmr_pkg::TAP_PA_IR;
      jcmr_pkg::TAP_EX2_IR: next_tap = tms_i ? jcmr_pkg::TAP_UPD_IR : jcmr_pkg::TAP_SH_IR;
      jcmr_pkg::TAP_UPD_IR: next_tap = tms_i ? jcmr_pkg::TAP_SEL_DR : jcmr_pkg::TAP_IDLE;
      default:              next_tap = jcmr_pkg::TAP_RESET;
    endcase
  end

  always_ff @(posedge tck_i) begin
    if (tck_rst) tap <= jcmr_pkg::TAP_RESET;
    else         tap <= next_tap;
  end

  // Instruction register, LSB first
  logic [9:0] ir_sr;
  logic [9:0] ir;
  always_ff @(posedge tck_i) begin
    if (tck_rst || tap == jcmr_pkg::TAP_RESET) begin
      ir_sr <= jcmr_pkg::IR_CAPTURE;
      ir    <= jcmr_pkg::IR_BYPASS;
    end else if (tap == jcmr_pkg::TAP_CAP_IR) begin
      ir_sr <= jcmr_pkg::IR_CAPTURE;
    end else if (tap == jcmr_pkg::TAP_SH_IR) begin
      ir_sr <= {tdi_i, ir_sr[9:1]};
    end else if (tap == jcmr_pkg::TAP_UPD_IR) begin
      ir <= ir_sr;
    end
  end

  wire sel_in   = (ir == jcmr_pkg::IR_CFG_IN);
  wire sel_out  = (ir == jcmr_pkg::IR_CFG_OUT);
  wire sel_sd   = (ir == jcmr_pkg::IR_SHUTDOWN);
  wire shift_dr = (tap == jcmr_pkg::TAP_SH_DR);
  wire cap_dr   = (tap == jcmr_pkg::TAP_CAP_DR);

  // Bit counter within a word, restarts at each capture
  logic [4:0] bit_cnt;
  always_ff @(posedge tck_i) begin
    if (tck_rst || cap_dr) bit_cnt <= 5'h00;
    else if (shift_dr)     bit_cnt <= bit_cnt + 5'h01;
  end
  wire word_end = shift_dr && (bit_cnt == jcmr_pkg::LAST_BIT);

  // Configuration input words, MSB first
  logic [31:0] in_sr;
  logic        bypass;
  wire [31:0]  new_word  = {in_sr[30:0], tdi_i};
  wire         word_done = word_end && sel_in;
  wire jcmr_pkg::jcmr_hdr_t hdr = new_word;
  always_ff @(posedge tck_i) begin
    if (tck_rst) begin
      in_sr  <= 32'h00000000;
      bypass <= 1'b0;
    end else if (shift_dr) begin
      in_sr  <= new_word;
      bypass <= tdi_i;
    end else if (cap_dr) begin
      bypass <= 1'b0;
    end
  end

  // Packet parser
  logic        synced;
  logic [4:0]  wr_addr;
  logic [10:0] wr_left;
  logic        read_configuration_command;
  logic        rd_arm;
  logic [31:0] frame_address_register;
  logic [26:0] rb_left;
  logic        stream;
  logic [7:0]  dummy_left;
  logic [31:0] out_sr;
  logic [31:0] addr_q;
  logic        req_tgl;
  logic        ack_s1;
  logic        ack_s2;
  logic        ack_tgl;
  logic [31:0] rd_hold;
  wire hdr_t1    = synced && wr_left == 11'h000
                   && hdr.kind == jcmr_pkg::HDR_TYPE1;
  wire hdr_t2    = synced && wr_left == 11'h000
                   && hdr.kind == jcmr_pkg::HDR_TYPE2 && rd_arm;
  wire data_word = synced && wr_left != 11'h000;
  wire cmd_word  = data_word && wr_addr == jcmr_pkg::REG_CMD;
  wire rd_frame  = hdr_t1 && hdr.op == jcmr_pkg::OP_READ
                   && hdr.addr == jcmr_pkg::REG_FRAME_RD;
  always_ff @(posedge tck_i) begin
    if (tck_rst || tap == jcmr_pkg::TAP_RESET) begin
      synced  <= 1'b0;
      wr_addr <= 5'h00;
      wr_left <= 11'h000;
    end else if (word_done) begin
      if (!synced) begin
        synced <= (new_word == jcmr_pkg::SYNC_WORD);
      end else if (data_word) begin
        wr_left <= wr_left - 11'h001;
      end else if (hdr_t1 && hdr.op == jcmr_pkg::OP_WRITE) begin
        wr_addr <= hdr.addr;
        wr_left <= hdr.count;
      end
    end
  end

  // Command, address and count state survives the TAP reset at the end
  always_ff @(posedge tck_i) begin
    if (tck_rst) begin
      read_configuration_command    <= 1'b0;
      rd_arm  <= 1'b0;
      frame_address_register     <= 32'h00000000;
      rb_left <= 27'h0000000;
    end else if (word_done) begin
      if (cmd_word && new_word[4:0] == jcmr_pkg::RESET_CRC_COMMAND) begin
        read_configuration_command   <= 1'b0;
        rd_arm <= 1'b0;
      end else if (cmd_word
                   && new_word[4:0] == jcmr_pkg::READ_CONFIGURATION_COMMAND) begin
        read_configuration_command <= 1'b1;
      end else if (data_word && wr_addr == jcmr_pkg::REG_FAR) begin
        frame_address_register <= new_word;
      end else if (rd_frame) begin
        rd_arm  <= 1'b1;
        rb_left <= {16'h0000, hdr.count};
      end else if (hdr_t2) begin
        rb_left <= new_word[26:0];
      end
    end else if (stream && word_end && rb_left != 27'h0000000) begin
      rb_left <= rb_left - 27'h0000001;
    end
  end

  // Shutdown: done stays low once the sequence starts
  logic [3:0] sd_cnt;
  logic       shut_done;
  logic       done_low;
  wire        sd_run = sel_sd && tap == jcmr_pkg::TAP_IDLE && !shut_done;
  always_ff @(posedge tck_i) begin
    if (tck_rst) begin
      sd_cnt    <= 4'h0;
      shut_done <= 1'b0;
      done_low  <= 1'b0;
    end else begin
      if (sd_run) sd_cnt <= sd_cnt + 4'h1;
      if (sd_run && sd_cnt == jcmr_pkg::SHUTDOWN_TCK - 4'h1) begin
        shut_done <= 1'b1;
      end
      done_low <= done_low || sd_run;
    end
  end

  // Readback stream; real words need a fetched, settled holding word
  wire data_ok   = (ack_s2 == req_tgl);
  wire next_real = dummy_left == 8'h00 && rb_left > 27'h0000001 && data_ok;
  wire start     = cap_dr && sel_out && read_configuration_command && rd_arm;
  always_ff @(posedge tck_i) begin
    if (tck_rst) begin
      stream     <= 1'b0;
      dummy_left <= 8'h00;
      out_sr     <= 32'h00000000;
      addr_q     <= 32'h00000000;
      req_tgl    <= 1'b0;
    end else if (start) begin
      stream     <= 1'b1;
      dummy_left <= jcmr_pkg::FRAME_WORDS - 8'h01;
      out_sr     <= 32'h00000000;
      addr_q     <= frame_address_register;
      req_tgl    <= !req_tgl;
    end else if (stream && word_end) begin
      if (dummy_left != 8'h00) dummy_left <= dummy_left - 8'h01;
      out_sr <= next_real ? rd_hold : 32'h00000000;
      if (next_real) begin
        addr_q  <= addr_q + 32'h00000001;
        req_tgl <= !req_tgl;
      end
    end else if (shift_dr && sel_out) begin
      out_sr <= {out_sr[30:0], 1'b0};
    end else if (tap == jcmr_pkg::TAP_RESET) begin
      stream <= 1'b0;
    end
  end

  always_ff @(posedge tck_i) begin
    ack_s1 <= tck_rst ? 1'b0 : ack_tgl;
    ack_s2 <= tck_rst ? 1'b0 : ack_s1;
  end

  // TDO changes on the falling edge so the host samples it settled
  wire tdo_bit = tap == jcmr_pkg::TAP_SH_IR ? ir_sr[0] :
                 sel_out ? out_sr[31] :
                 sel_in  ? in_sr[31]  : bypass;
  always_ff @(negedge tck_i) begin
    if (tck_rst) begin
      tdo_o    <= 1'b0;
      tdo_en_o <= 1'b0;
    end else begin
      tdo_o    <= tdo_bit;
      tdo_en_o <= shift_dr || tap == jcmr_pkg::TAP_SH_IR;
    end
  end

  // System side: fetch on request toggle, answer by ack toggle
  logic req_s1;
  logic req_s2;
  logic req_s3;
  logic dl_s1;
  logic dl_s2;
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      req_s1    <= 1'b0;
      req_s2    <= 1'b0;
      req_s3    <= 1'b0;
      rd_req_o  <= 1'b0;
      rd_addr_o <= 32'h00000000;
      rd_hold   <= 32'h00000000;
      ack_tgl   <= 1'b0;
      dl_s1     <= 1'b0;
      dl_s2     <= 1'b0;
    end else begin
      req_s1   <= req_tgl;
      req_s2   <= req_s1;
      req_s3   <= req_s2;
      rd_req_o <= req_s2 != req_s3;
      if (req_s2 != req_s3) rd_addr_o <= addr_q;
      if (rd_req_o) begin
        rd_hold <= rd_data_i;
        ack_tgl <= req_s3;
      end
      dl_s1 <= done_low;
      dl_s2 <= dl_s1;
    end
  end
  assign done_o = !dl_s2;

  default clocking cb @(posedge tck_i); endclocking
  default disable iff (tck_rst);

  chk_tap_reset: assert property (tms_i [*5] |=> tap == jcmr_pkg::TAP_RESET)
    else $error("five TMS highs did not reach reset");
  chk_ir_update: assert property (tap == jcmr_pkg::TAP_UPD_IR |=> ir == $past(ir_sr))
    else $error("instruction not updated");
  chk_word_order: assert property (shift_dr && sel_in |=> in_sr[0] == $past(tdi_i)
      && in_sr[31:1] == $past(in_sr[30:0]))
    else $error("input word not MSB first");
  chk_sync_seen: assert property (word_done && !synced
      && new_word == jcmr_pkg::SYNC_WORD |=> synced)
    else $error("sync word missed");
  chk_dummy_frame: assert property (start |=> out_sr == 32'h00000000
      && dummy_left == jcmr_pkg::FRAME_WORDS - 8'h01)
    else $error("dummy frame not first");
  chk_dummy_zero: assert property (stream && word_end && dummy_left != 8'h00
      |=> out_sr == 32'h00000000)
    else $error("dummy word not zero");
  chk_done_low: assert property (sd_run |=> done_low [*3])
    else $error("done not low in shutdown");
  chk_shutdown_len: assert property ($rose(shut_done)
      |-> $past(sd_cnt) == jcmr_pkg::SHUTDOWN_TCK - 4'h1)
    else $error("shutdown length wrong");
  chk_type2_count: assert property (word_done && hdr_t2 && !cmd_word
      |=> rb_left == $past(new_word[26:0]))
    else $error("type-2 count not taken");
  chk_real_fetch: assert property (stream && word_end && next_real
      |=> out_sr == $past(rd_hold) && req_tgl != $past(req_tgl))
    else $error("real word not loaded");

  cov_shutdown: cover property ($rose(shut_done));
  cov_stream: cover property (start ##[1:300] (stream && word_end));
  cov_real: cover property (stream && word_end && next_real);
endmodule

/* File: dv/jcmr_host_model.sv */
// Test-port host model: drives the link clock, mode select and data in.
// Assumes the device updates tdo_o on the falling link clock edge.
`timescale 1ns/1ps
module jcmr_host_model (
  // Test port toward the device
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  input  wire logic tdo_i,
  input  wire logic tdo_en_i
);
  logic seen_tdo;
  logic seen_en;

  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
    seen_tdo = 1'b0;
    seen_en = 1'b0;
  end

  // One 30 ns link clock; clock stands low between calls
  task automatic step(input logic tms, input logic tdi);
    tms_o <= tms;
    tdi_o <= tdi;
    #15;
    seen_tdo = tdo_i;
    seen_en = tdo_en_i;
    tck_o <= 1'b1;
    #15;
    tck_o <= 1'b0;
  endtask

  // Unused data in toggles so a stale level never looks meaningful
  task automatic tms_run(input int n, input logic v);
    for (int i = 0; i < n; i++) begin
      step(v, i[0]);
    end
  endtask

  // Ten bits LSB first, last one leaves Shift-IR
  task automatic load_ir(input logic [9:0] code);
    for (int i = 0; i < 10; i++) begin
      step(i == 9, code[i]);
    end
  endtask

  // MSB first; last bit of the last word leaves Shift-DR
  task automatic shift_word(input logic [31:0] w, input logic last,
                            output logic [31:0] o);
    for (int i = 31; i >= 0; i--) begin
      step(last && (i == 0), w[i]);
      o[i] = seen_tdo;
    end
  endtask
endmodule

/* File: dv/jcmr_readback_tb_top.sv */
// Self-checking bench for the configuration readback block.
// Assumes a zero-latency frame memory answering in the request cycle.
`timescale 1ns/1ps
module jcmr_readback_tb_top;
  localparam int          NWORDS     = 84;
  localparam logic [31:0] ADDR_START = 32'h00000010;
  logic        clk_i;
  logic        reset_n_i;
  logic        tck_i;
  logic        tms_i;
  logic        tdi_i;
  logic        tdo_o;
  logic        tdo_en_o;
  logic        rd_req_o;
  logic        done_o;
  logic [31:0] rd_addr_o;
  logic [31:0] rd_data_i;
  logic [1:0]  junk;
  int          num_errors;
  int          check_count;

  initial begin
    clk_i = 1'b0;
    reset_n_i = 1'b0;
    junk = 2'h0;
    num_errors = 0;
    check_count = 0;
  end
  always #5 clk_i = ~clk_i;
  always_ff @(posedge clk_i) junk <= junk + 2'h1;
  // Off-request data changes every cycle so stale words are caught
  assign rd_data_i = rd_req_o ? (32'hC3000000 ^ rd_addr_o) : {16{junk}};

  jcmr_readback u_jcmr_readback (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i), .tdo_o(tdo_o),
    .tdo_en_o(tdo_en_o), .rd_req_o(rd_req_o), .rd_addr_o(rd_addr_o),
    .rd_data_i(rd_data_i), .done_o(done_o));
  jcmr_host_model u_jcmr_host_model (.tck_o(tck_i), .tms_o(tms_i),
    .tdi_o(tdi_i), .tdo_i(tdo_o), .tdo_en_i(tdo_en_o));

  task automatic check_word(input string nm, input logic [31:0] e,
                            input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic check_bit(input string nm, input logic e, input logic g);
    check_word(nm, {31'h0, e}, {31'h0, g});
  endtask

  function automatic logic [31:0] hdr1(input logic [1:0] op,
                                       input logic [4:0] adr,
                                       input logic [10:0] cnt);
    jcmr_pkg::jcmr_hdr_t h;
    h = '0;
    h.kind = jcmr_pkg::HDR_TYPE1;
    h.op = op;
    h.addr = adr;
    h.count = cnt;
    return h;
  endfunction

  task automatic send(input logic [31:0] q[$]);
    logic [31:0] o;
    for (int i = 0; i < q.size(); i++) begin
      u_jcmr_host_model.shift_word(q[i], i == q.size() - 1, o);
      check_bit("tdo_en in shift", 1'b1, u_jcmr_host_model.seen_en);
    end
  endtask

  task automatic t_reset();
    fork
      u_jcmr_host_model.tms_run(4, 1'b1);
      begin
        repeat (9) @(posedge clk_i);
        reset_n_i <= 1'b1;
      end
    join
    u_jcmr_host_model.tms_run(5, 1'b1);
    @(posedge clk_i);
    #1;
    check_bit("done after reset", 1'b1, done_o);
    check_bit("rd_req idle", 1'b0, rd_req_o);
    check_bit("tdo_en idle", 1'b0, tdo_en_o);
    u_jcmr_host_model.tms_run(1, 1'b0);
    u_jcmr_host_model.tms_run(2, 1'b1);
    u_jcmr_host_model.tms_run(2, 1'b0);
  endtask

  task automatic t_group1();
    logic [31:0] q[$];
    q = '{32'hFFFFFFFF, jcmr_pkg::SYNC_WORD, 32'h20000000,
          hdr1(jcmr_pkg::OP_WRITE, jcmr_pkg::REG_CMD, 11'h001),
          {27'h0, jcmr_pkg::RESET_CRC_COMMAND}, 32'h20000000, 32'h20000000};
    u_jcmr_host_model.load_ir(jcmr_pkg::IR_CFG_IN);
    u_jcmr_host_model.tms_run(2, 1'b1);
    u_jcmr_host_model.tms_run(2, 1'b0);
    send(q);
    u_jcmr_host_model.tms_run(3, 1'b1);
    u_jcmr_host_model.tms_run(2, 1'b0);
    check_bit("done before shutdown", 1'b1, done_o);
  endtask

  task automatic t_shutdown();
    u_jcmr_host_model.load_ir(jcmr_pkg::IR_SHUTDOWN);
    u_jcmr_host_model.tms_run(1, 1'b1);
    u_jcmr_host_model.tms_run(2, 1'b0);
    // Done crosses into the system clock through two flops
    repeat (3) @(posedge clk_i);
    #1;
    check_bit("done in shutdown", 1'b0, done_o);
    u_jcmr_host_model.tms_run(10, 1'b0);
    check_bit("done after shutdown", 1'b0, done_o);
    u_jcmr_host_model.tms_run(2, 1'b1);
    u_jcmr_host_model.tms_run(2, 1'b0);
  endtask

  task automatic t_group2();
    logic [31:0] q[$];
    jcmr_pkg::jcmr_hdr_t h2;
    h2 = '0;
    h2.kind = jcmr_pkg::HDR_TYPE2;
    h2.op = jcmr_pkg::OP_READ;
    {h2.rsv_hi, h2.addr, h2.rsv_lo, h2.count} = 27'(NWORDS);
    q = '{32'hFFFFFFFF, jcmr_pkg::SYNC_WORD, 32'h20000000,
          hdr1(jcmr_pkg::OP_WRITE, jcmr_pkg::REG_CMD, 11'h001),
          {27'h0, jcmr_pkg::READ_CONFIGURATION_COMMAND},
          hdr1(jcmr_pkg::OP_WRITE, jcmr_pkg::REG_FAR, 11'h001), ADDR_START,
          hdr1(jcmr_pkg::OP_READ, jcmr_pkg::REG_FRAME_RD, 11'h000), h2,
          32'h20000000, 32'h20000000};
    u_jcmr_host_model.load_ir(jcmr_pkg::IR_CFG_IN);
    u_jcmr_host_model.tms_run(2, 1'b1);
    u_jcmr_host_model.tms_run(2, 1'b0);
    send(q);
    u_jcmr_host_model.tms_run(3, 1'b1);
    u_jcmr_host_model.tms_run(2, 1'b0);
  endtask

  // One word past the count: the device must pad it with zeros
  task automatic t_readback();
    logic [31:0] o;
    logic [31:0] e;
    int          fw;
    fw = int'(jcmr_pkg::FRAME_WORDS);
    u_jcmr_host_model.load_ir(jcmr_pkg::IR_CFG_OUT);
    u_jcmr_host_model.tms_run(2, 1'b1);
    u_jcmr_host_model.tms_run(2, 1'b0);
    for (int k = 0; k <= NWORDS; k++) begin
      u_jcmr_host_model.shift_word({16{2'h1}}, k == NWORDS, o);
      e = (k < fw || k >= NWORDS) ? 32'h0 :
          32'hC3000000 ^ (ADDR_START + 32'(k - fw));
      check_word("readback word", e, o);
    end
    u_jcmr_host_model.tms_run(3, 1'b1);
    u_jcmr_host_model.tms_run(2, 1'b0);
    u_jcmr_host_model.tms_run(5, 1'b1);
    check_bit("tdo_en after reset", 1'b0, tdo_en_o);
    check_bit("done stays low", 1'b0, done_o);
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    t_reset();
    t_group1();
    t_shutdown();
    t_group2();
    t_readback();
    wrap_up();
  end

  // Hang guard: far beyond the whole sequence
  initial begin
    #500000;
    num_errors++;
    wrap_up();
  end
endmodule
